// ---- core/smb_pkg.sv ----
// shared constants and types for the smbus slave and its host end
// assumes a 250 mhz reference clock on both ends
package smb_pkg;

  // ----------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------
  localparam int CLK_KHZ = 250000;       // reference clock rate
  localparam int TMO_MS = 25;            // bus inactivity limit
  // cycles of a stuck line before the slave abandons the frame
  localparam int TMO_CYCLES = TMO_MS * CLK_KHZ;
  localparam int SCL_KHZ = 100;          // host serial clock rate
  // host quarter bit, rounded down so the bus never runs slow
  localparam int QTR_CYCLES = CLK_KHZ / (4 * SCL_KHZ);

  // ----------------------------------------------------------
  // bus addresses
  // ----------------------------------------------------------
  localparam logic [6:0] ADDR_MAIN = 7'h4C;  // standard build
  localparam logic [6:0] ADDR_ALT = 7'h4B;   // variant build
  localparam logic [6:0] ARA_ADDR = 7'h0C;   // alert response

  // ----------------------------------------------------------
  // slave register: consecutive alarm config
  // ----------------------------------------------------------
  localparam logic [7:0] CFG_OFF = 8'h22;
  localparam logic [7:0] CFG_RST = 8'h01;
  localparam int CFG_SCL_TMO = 7;        // clock line timeout on
  localparam int CFG_SDA_TMO = 6;        // data line timeout on
  localparam logic [7:0] CRC_POLY = 8'h07;   // x^8+x^2+x+1
  localparam logic [7:0] IDLE_BYTE = 8'hFF;  // sent past the pec

  // ----------------------------------------------------------
  // host register map and fields
  // ----------------------------------------------------------
  localparam logic [2:0] H_CTRL = 3'h0;
  localparam logic [2:0] H_ADDR = 3'h1;
  localparam logic [2:0] H_DATA0 = 3'h2;
  localparam logic [2:0] H_DATA1 = 3'h3;
  localparam logic [2:0] H_STAT = 3'h4;
  localparam logic [2:0] H_RDATA = 3'h5;
  localparam logic [2:0] H_RPEC = 3'h6;
  localparam int C_GO = 0;               // ctrl: start a frame
  localparam int C_RW = 1;               // ctrl: 1 = read
  localparam int C_PEC = 2;              // ctrl: add pec byte
  localparam int C_NB = 4;               // ctrl: data count lsb

  // ----------------------------------------------------------
  // state encodings, gray along the usual path
  // ----------------------------------------------------------
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_RX = 3'b001,
    D_ACK = 3'b011,
    D_TX = 3'b010,
    D_RACK = 3'b110
  } dst_type;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_BITS = 2'b11,
    H_STOP = 2'b10
  } hst_type;

endpackage

// ---- core/smb_if.sv ----
// two-wire bus plus alert line joining the host and the slave
// assumes open-drain pins: a driver only ever pulls low
`timescale 1ns/100ps
interface smb_if;

  // ----------------------------------------------------------
  // pin drivers, output and enable per party
  // ----------------------------------------------------------
  logic scl_h_o;      // host clock drive value
  logic scl_h_oe;     // host pulls clock
  logic sda_h_o;      // host data drive value
  logic sda_h_oe;     // host pulls data
  logic sda_d_o;      // slave data drive value
  logic sda_d_oe;     // slave pulls data
  logic alert_d_o;    // slave alarm drive value
  logic alert_d_oe;   // slave pulls alarm
  logic scl;          // resolved clock level
  logic sda;          // resolved data level
  logic alert_n;      // resolved alarm level, low = alarm

  // pull-ups: released lines read high
  assign scl = scl_h_oe ? scl_h_o : 1'b1;
  assign sda = (sda_h_oe ? sda_h_o : 1'b1)
             & (sda_d_oe ? sda_d_o : 1'b1);
  assign alert_n = alert_d_oe ? alert_d_o : 1'b1;

  modport device (
    input scl, sda,
    output sda_d_o, sda_d_oe, alert_d_o, alert_d_oe
  );
  modport host (
    input scl, sda, alert_n,
    output scl_h_o, scl_h_oe, sda_h_o, sda_h_oe
  );

endinterface

// ---- core/crc8_byte.sv ----
// one byte step of the packet error check, x^8+x^2+x+1
// assumes msb-first byte order, as on the wire
`timescale 1ns/100ps
module crc8_byte
  import smb_pkg::*;
(
  input wire logic [7:0] crc_i,
  input wire logic [7:0] data_i,
  output logic [7:0] crc_o
);

  // ----------------------------------------------------------
  // eight serial steps unrolled by the loop
  // ----------------------------------------------------------
  always_comb
  begin
    crc_o = crc_i ^ data_i;
    for (int i = 0; i < 8; i++)
    begin
      crc_o = crc_o[7] ? ((crc_o << 1) ^ CRC_POLY) : (crc_o << 1);
    end
  end

endmodule

// ---- core/smbus_slave_alert_port.sv ----
// slave end of the two-wire bus with alarm and alert response
// assumes a host that makes the clock; clock and data sampled
// through two flops on ref_clk_i before any logic sees them
//
// How it works
// RULE1: stuck bus abandons frame; timeouts reset off
// RULE2: config bit 7 enables clock timeout
// RULE3: config bit 6 enables data timeout
// RULE4: extra byte after transfer is the pec
// RULE5: pec is crc-8, x^8+x^2+x+1
// RULE6: answer only own fixed seven-bit address
// RULE7: after start shift address then direction
// RULE8: acknowledge own address, otherwise stay idle
// RULE9: direction 0 writes, 1 reads
// RULE10: nine clocks per byte, data moves clock-low
// RULE11: master ends write with a stop
// RULE12: master ends read with nack then stop
// RULE13: direction holds for whole operation
// RULE14: writes carry one or two bytes, reads one
// RULE15: first byte sets pointer, second is stored
// RULE16: read returns register under the pointer
// RULE17: master sets read or write offset first
// RULE18: alarm pulls open-drain line low
// RULE19: alert response returns own address plus one
// RULE20: lost arbitration backs the slave off
// RULE21: alarm released after response if condition gone
// RULE22: master repeats alert response while line low
// RULE23: crc starts zero at start, covers all bytes
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
module smbus_slave_alert_port
  import smb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = ADDR_MAIN,
  parameter int TMO_CYC = TMO_CYCLES
)
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  smb_if.device bus,
  input wire logic alarm_cond_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic pec_err_o,
  output logic [7:0] cfg_o
);

  localparam int TW = $clog2(TMO_CYC + 1);

  // ----------------------------------------------------------
  // whole state of the slave
  // ----------------------------------------------------------
  typedef struct packed {
    logic [1:0] scl_sy;   // clock synchroniser, bit 0 first
    logic [1:0] sda_sy;   // data synchroniser, bit 0 first
    logic scl_q;          // clock one sample back
    logic sda_q;          // data one sample back
    dst_type st;          // bit engine state
    logic [3:0] bcnt;     // bits done in this byte
    logic [7:0] sh;       // byte in or out
    logic addr_ph;        // next byte is the address
    logic rw;             // direction of this operation
    logic ara;            // answering the alert response
    logic active;         // inside start..stop
    logic [1:0] nbyte;    // data bytes in this operation
    logic [7:0] ptr;      // register pointer
    logic [7:0] wbuf;     // data waiting for the stop
    logic [7:0] cfg;      // consecutive alarm config
    logic [7:0] crc;      // running check over the frame
    logic alarm;          // alarm latch, drives the pin
    logic [TW-1:0] tmo;   // inactivity counter
    logic sda_oe;         // pulling data low
    logic wr;             // register write pulse
    logic perr;           // check failure pulse
  } dev_type;

  dev_type r;             // registered state
  dev_type n;             // next state
  logic scl;              // synchronised clock
  logic sda;              // synchronised data
  logic start;            // data fell while clock high
  logic stop;             // data rose while clock high
  logic rise;             // clock rising edge
  logic fall;             // clock falling edge
  logic clr;              // alert response completed
  logic stuck;            // an enabled line sits low
  logic [7:0] crc_nx;     // check after the current byte
  logic [7:0] rdsel;      // register under the pointer
  logic [7:0] txb;        // next byte to send

  // ----------------------------------------------------------
  // line events, from the second synchroniser stage on
  // ----------------------------------------------------------
  assign scl = r.scl_sy[1];
  assign sda = r.sda_sy[1];
  // RULE7: start detect
  assign start = scl & r.scl_q & r.sda_q & ~sda;
  assign stop = scl & r.scl_q & ~r.sda_q & sda;
  assign rise = scl & ~r.scl_q;
  assign fall = ~scl & r.scl_q;

  // RULE16: pointer selects
  assign rdsel = (r.ptr == CFG_OFF) ? r.cfg : reg_rdata_i;

  // RULE5: byte check step
  crc8_byte u_crc (
    .crc_i(r.crc),
    .data_i(r.sh),
    .crc_o(crc_nx)
  );

  // RULE2: clock timeout gate
  // RULE3: data timeout gate
  assign stuck = (r.cfg[CFG_SCL_TMO] & ~scl)
               | (r.cfg[CFG_SDA_TMO] & ~sda);

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  always_comb
  begin
    n = r;
    clr = 1'b0;
    txb = IDLE_BYTE;
    n.wr = 1'b0;
    n.perr = 1'b0;
    n.scl_sy = {r.scl_sy[0], bus.scl};
    n.sda_sy = {r.sda_sy[0], bus.sda};
    n.scl_q = scl;
    n.sda_q = sda;
    // RULE1: count quiet time
    if (stuck && scl == r.scl_q && sda == r.sda_q)
    begin
      n.tmo = (r.tmo == TW'(TMO_CYC)) ? r.tmo : r.tmo + 1'b1;
    end
    else
    begin
      n.tmo = '0;
    end
    // RULE1: abandon the frame
    if (r.tmo == TW'(TMO_CYC - 1))
    begin
      n.st = D_IDLE;
      n.active = 1'b0;
      n.sda_oe = 1'b0;
      n.nbyte = '0;
    end
    else if (stop)
    begin
      // RULE15: commit on stop
      if (r.active && !r.rw && (r.nbyte == 2'd2
          || (r.nbyte == 2'd3 && r.crc == 8'h00)))
      begin
        if (r.ptr == CFG_OFF)
        begin
          n.cfg = r.wbuf;
        end
        else
        begin
          n.wr = 1'b1;
        end
      end
      // RULE4: bad pec drops the write
      n.perr = r.active & ~r.rw & (r.nbyte == 2'd3)
             & (r.crc != 8'h00);
      n.st = D_IDLE;
      n.active = 1'b0;
      n.sda_oe = 1'b0;
    end
    else if (start)
    begin
      // RULE23: fresh check only at first start
      if (!r.active)
      begin
        n.crc = 8'h00;
      end
      n.active = 1'b1;
      n.st = D_RX;
      n.addr_ph = 1'b1;
      n.bcnt = '0;
      n.nbyte = '0;
      n.sda_oe = 1'b0;
    end
    else
    begin
      case (r.st)
        D_RX:
        begin
          // RULE10: sample while clock high
          if (rise)
          begin
            n.sh = {r.sh[6:0], sda};
            n.bcnt = r.bcnt + 1'b1;
          end
          else if (fall && r.bcnt == 4'd8)
          begin
            n.crc = crc_nx;
            n.bcnt = '0;
            n.st = D_ACK;
            n.sda_oe = 1'b1;
            if (r.addr_ph)
            begin
              n.addr_ph = 1'b0;
              n.ara = 1'b0;
              // RULE6: own address only
              // RULE9: direction bit
              if (r.sh[7:1] == DEV_ADDR)
              begin
                n.rw = r.sh[0];
              end
              // RULE19: alert response while alarmed
              else if (r.sh[7:1] == ARA_ADDR && r.sh[0] && r.alarm)
              begin
                n.rw = 1'b1;
                n.ara = 1'b1;
              end
              // RULE8: not ours, stay idle
              else
              begin
                n.st = D_IDLE;
                n.active = 1'b0;
                n.sda_oe = 1'b0;
              end
            end
            // RULE14: more than pointer, data and pec refused
            else if (r.nbyte == 2'd3)
            begin
              n.st = D_IDLE;
              n.sda_oe = 1'b0;
            end
            else
            begin
              // RULE15: first byte is the pointer
              if (r.nbyte == 2'd0)
              begin
                n.ptr = r.sh;
              end
              else if (r.nbyte == 2'd1)
              begin
                n.wbuf = r.sh;
              end
              n.nbyte = r.nbyte + 1'b1;
            end
          end
        end
        D_ACK:
        begin
          // RULE8: hold ack through the ninth clock
          if (fall)
          begin
            // RULE13: direction fixed by address byte
            if (r.rw)
            begin
              txb = r.ara ? {DEV_ADDR, 1'b1} : rdsel;
              n.sh = txb;
              n.sda_oe = ~txb[7];
              n.st = D_TX;
            end
            else
            begin
              n.sda_oe = 1'b0;
              n.st = D_RX;
            end
          end
        end
        D_TX:
        begin
          if (rise)
          begin
            n.bcnt = r.bcnt + 1'b1;
            // RULE20: released bit seen low, back off
            if (r.sh[3'(4'd7 - r.bcnt)] && !sda)
            begin
              n.st = D_IDLE;
              n.sda_oe = 1'b0;
            end
          end
          else if (fall)
          begin
            if (r.bcnt == 4'd8)
            begin
              n.crc = crc_nx;
              n.sda_oe = 1'b0;
              n.st = D_RACK;
              n.nbyte = (r.nbyte == 2'd3) ? r.nbyte : r.nbyte + 1'b1;
              // RULE21: response sent
              clr = r.ara & (r.nbyte == 2'd0);
            end
            else
            begin
              // RULE10: change data while clock low
              n.sda_oe = ~r.sh[3'(4'd7 - r.bcnt)];
            end
          end
        end
        D_RACK:
        begin
          // RULE12: master nack ends the read
          if (rise && sda)
          begin
            n.st = D_IDLE;
          end
          else if (fall)
          begin
            // RULE4: acked read byte is followed by pec
            txb = (r.nbyte == 2'd1) ? r.crc : IDLE_BYTE;
            n.sh = txb;
            n.sda_oe = ~txb[7];
            n.bcnt = '0;
            n.st = D_TX;
          end
        end
        default:
        begin
          n.sda_oe = 1'b0;
        end
      endcase
    end
    // RULE18: condition sets alarm, set wins
    // RULE21: clear only when condition gone
    n.alarm = alarm_cond_i | (r.alarm & ~clr);
  end

  // ----------------------------------------------------------
  // state register; lines idle high, config to its default
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      r <= '0;
      r.scl_sy <= 2'b11;
      r.sda_sy <= 2'b11;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
      // RULE1: timeouts off at power-on
      r.cfg <= CFG_RST;
    end
    else
    begin
      r <= n;
    end
  end

  // ----------------------------------------------------------
  // pins and user side
  // ----------------------------------------------------------
  assign bus.sda_d_o = 1'b0;
  assign bus.sda_d_oe = r.sda_oe;
  assign bus.alert_d_o = 1'b0;
  // RULE18: open-drain alarm
  assign bus.alert_d_oe = r.alarm;
  assign reg_addr_o = r.ptr;
  assign reg_wdata_o = r.wbuf;
  assign reg_wr_o = r.wr;
  assign pec_err_o = r.perr;
  assign cfg_o = r.cfg;

endmodule

// ---- core/smbus_host_master.sv ----
// host end: drives the bus clock and runs one operation at a time
// assumes software on a plain register port, one cycle read data
`timescale 1ns/100ps
module smbus_host_master
  import smb_pkg::*;
#(
  parameter int QTR = QTR_CYCLES
)
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  smb_if.host bus,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o
);

  localparam int QW = $clog2(QTR + 1);

  // ----------------------------------------------------------
  // whole state of the host
  // ----------------------------------------------------------
  typedef struct packed {
    logic [1:0] sda_sy;   // data synchroniser
    logic [1:0] alr_sy;   // alert synchroniser
    hst_type st;
    logic [QW-1:0] div;   // quarter bit divider
    logic [1:0] ph;       // quarter within a bit
    logic [3:0] bcnt;     // bit within a byte, 8 = ack
    logic [1:0] k;        // byte index, 0 = address
    logic rw, pec;
    logic [1:0] nb;       // data bytes to write
    logic [6:0] addr;
    logic [7:0] d0, d1, sh, rdata, rpec, crc, rd;
    logic nack, perr, scl_oe, sda_oe;
  } hst_st_type;

  hst_st_type r;
  hst_st_type n;
  logic tick;             // quarter boundary
  logic tx;               // host sends this byte
  logic [1:0] last;       // index of the final byte
  logic [7:0] txb;        // byte to send
  logic [7:0] crc_nx;

  assign tick = (r.div == '0);
  assign tx = (r.k == 2'd0) | ~r.rw;
  // RULE14: one read byte; writes take nb data bytes from the 2-bit field, up to three without pec; nb of three with pec wraps last to 0
  assign last = r.rw ? (r.pec ? 2'd2 : 2'd1) : r.nb + {1'b0, r.pec};
  // RULE4: pec follows the data
  assign txb = (r.k == 2'd0) ? {r.addr, r.rw}
             : (r.k > r.nb) ? r.crc
             : (r.k == 2'd1) ? r.d0 : r.d1;

  crc8_byte u_crc (
    .crc_i(r.crc),
    .data_i(tx ? txb : r.sh),
    .crc_o(crc_nx)
  );

  // ----------------------------------------------------------
  // next state: register port, then quarter bit engine
  // ----------------------------------------------------------
  always_comb
  begin
    n = r;
    n.sda_sy = {r.sda_sy[0], bus.sda};
    n.alr_sy = {r.alr_sy[0], bus.alert_n};
    n.div = (r.st == H_IDLE || tick) ? QW'(QTR - 1) : r.div - 1'b1;
    // read data is taken only on a read strobe and then held
    if (rd_i)
    begin
      case (addr_i)
        H_CTRL: n.rd = {2'b00, r.nb, 1'b0, r.pec, r.rw, 1'b0};
        H_ADDR: n.rd = {1'b0, r.addr};
        H_DATA0: n.rd = r.d0;
        H_DATA1: n.rd = r.d1;
        H_STAT: n.rd = {4'h0, ~r.alr_sy[1], r.perr, r.nack,
                        r.st != H_IDLE};
        H_RDATA: n.rd = r.rdata;
        H_RPEC: n.rd = r.rpec;
        default: n.rd = 8'h00;
      endcase
    end
    // writes are ignored while an operation runs
    if (wr_i && r.st == H_IDLE)
    begin
      case (addr_i)
        H_ADDR: n.addr = wdata_i[6:0];
        H_DATA0: n.d0 = wdata_i;
        H_DATA1: n.d1 = wdata_i;
        H_CTRL:
        begin
          n.rw = wdata_i[C_RW];
          n.pec = wdata_i[C_PEC];
          n.nb = wdata_i[C_NB+1:C_NB];
          if (wdata_i[C_GO])
          begin
            n.st = H_START;
            n.ph = '0;
            n.k = '0;
            n.bcnt = '0;
            // RULE23: check starts from zero
            n.crc = 8'h00;
            n.nack = 1'b0;
            n.perr = 1'b0;
          end
        end
        default: n.rd = r.rd;
      endcase
    end
    if (tick && r.st != H_IDLE)
    begin
      n.ph = r.ph + 1'b1;
      case (r.st)
        H_START:
        begin
          // RULE7: data falls while clock high
          case (r.ph)
            2'd0: n.sda_oe = 1'b0;
            2'd1: n.sda_oe = 1'b1;
            2'd2: n.scl_oe = 1'b1;
            default: n.st = H_BITS;
          endcase
        end
        H_BITS:
        begin
          case (r.ph)
            // RULE10: data set while clock low
            2'd0: n.sda_oe = (r.bcnt < 4'd8)
                    ? tx & ~txb[3'(4'd7 - r.bcnt)]
                    : ~tx & (r.k != last);
            2'd1: n.scl_oe = 1'b0;
            2'd2:
            begin
              if (r.bcnt < 4'd8 && !tx)
              begin
                n.sh = {r.sh[6:0], r.sda_sy[1]};
              end
              if (r.bcnt == 4'd8 && tx)
              begin
                n.nack = r.nack | r.sda_sy[1];
              end
            end
            default:
            begin
              n.scl_oe = 1'b1;
              n.bcnt = r.bcnt + 1'b1;
              if (r.bcnt == 4'd7)
              begin
                n.crc = crc_nx;
              end
              if (r.bcnt == 4'd8)
              begin
                n.bcnt = '0;
                if (!tx && r.k == 2'd1)
                begin
                  n.rdata = r.sh;
                end
                if (!tx && r.k == 2'd2)
                begin
                  n.rpec = r.sh;
                  n.perr = (r.crc != 8'h00);
                end
                // RULE11: stop after the last write byte
                // RULE12: nack given on last read byte
                if (r.nack || r.k == last)
                begin
                  n.st = H_STOP;
                end
                else
                begin
                  n.k = r.k + 1'b1;
                end
              end
            end
          endcase
        end
        default:
        begin
          // data low, clock up, data rises: stop
          case (r.ph)
            2'd0: n.sda_oe = 1'b1;
            2'd1: n.scl_oe = 1'b0;
            2'd2: n.sda_oe = 1'b0;
            default: n.st = H_IDLE;
          endcase
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // state register
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      r <= '0;
      r.sda_sy <= 2'b11;
      r.alr_sy <= 2'b11;
    end
    else
    begin
      r <= n;
    end
  end

  assign bus.scl_h_o = 1'b0;
  assign bus.scl_h_oe = r.scl_oe;
  assign bus.sda_h_o = 1'b0;
  assign bus.sda_h_oe = r.sda_oe;
  assign rdata_o = r.rd;

endmodule

// ---- bench/smb_asserts.sv ----
// wire checker for the slave end of the two-wire link
// assumes it sits on the resolved wires of the single smb_if
`timescale 1ns/100ps
module smb_asserts
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic alert_n,
  input wire logic sda_d_oe,
  input wire logic alert_d_oe
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  // start: data falls while the clock is high
  sequence start_s;
    $fell(sda) && scl;
  endsequence
  a_hold_clk_high:
    assert property (scl && $past(scl) |-> $stable(sda_d_oe))
    else $error("slave data moved with clock high");
  a_pull_clk_low:
    assert property ($rose(sda_d_oe) |-> !scl)
    else $error("slave pulled data with clock high");
  a_pull_held:
    assert property ($rose(sda_d_oe) |-> sda_d_oe [*8])
    else $error("slave pull too short");
  a_pull_bounded:
    assert property ($rose(sda_d_oe) |-> ##[1:200] !sda_d_oe)
    else $error("slave pull never released");
  a_addr_quiet:
    assert property (start_s |-> ##150 !sda_d_oe)
    else $error("slave drove during address byte");
  a_start_clean:
    assert property (start_s |-> !sda_d_oe)
    else $error("slave took part in a start");
  a_alert_wire:
    assert property (alert_n == !alert_d_oe)
    else $error("alarm line not following slave pull");
  a_alert_free_low:
    assert property ($fell(alert_d_oe) |-> !scl)
    else $error("alarm freed away from a clock fall");
  c_ack: cover property ($rose(sda_d_oe));
  c_start: cover property (start_s);
  c_alert_freed: cover property ($fell(alert_d_oe));
endmodule

// ---- bench/tb.sv ----
// bench: host and slave joined by smb_if, run over host registers
// assumes short counts, five cycles a quarter bit is the minimum
`timescale 1ns/100ps
module tb;
  import smb_pkg::*;
  logic ref_clk_i = 0;
  logic reset_i = 1;
  logic [2:0] addr_i = 0;
  logic [7:0] wdata_i = 0;
  logic wr_i = 0;
  logic rd_i = 0;
  logic alarm_cond_i = 0;
  logic [7:0] rdata_o, reg_addr_o, reg_wdata_o, cfg_o, wa, wd;
  logic reg_wr_o, pec_err_o;
  int fail_count = 0;
  int check_count = 0;
  int wr_seen = 0;
  int pec_errs = 0;
  smb_if bus ();
  smbus_host_master #(.QTR(5)) i_smbus_host_master (.ref_clk_i,
    .reset_i, .bus, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o);
  smbus_slave_alert_port #(.TMO_CYC(200)) i_smbus_slave_alert_port (
    .ref_clk_i, .reset_i, .bus, .alarm_cond_i, .reg_addr_o,
    .reg_rdata_i(reg_addr_o ^ 8'hA5), .reg_wdata_o, .reg_wr_o,
    .pec_err_o, .cfg_o);
  smb_asserts i_smb_asserts (.ref_clk_i, .reset_i, .scl(bus.scl),
    .sda(bus.sda), .alert_n(bus.alert_n), .sda_d_oe(bus.sda_d_oe),
    .alert_d_oe(bus.alert_d_oe));
  always #2 ref_clk_i = ~ref_clk_i;
  // user-side write log, pulses are one cycle only
  always @(posedge ref_clk_i)
  begin
    if (reg_wr_o === 1'b1)
      {wa, wd} <= {reg_addr_o, reg_wdata_o};
    wr_seen += reg_wr_o;
    pec_errs += pec_err_o;
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1;
    @(posedge ref_clk_i);
    wr_i <= 0;
  endtask
  // read data appears in the cycle after the strobe and holds until the next read
  task automatic rd(logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1;
    @(posedge ref_clk_i);
    rd_i <= 0;
    #1 d = rdata_o;
  endtask
  // load target and bytes, go, then poll busy with a bound
  task automatic op(logic [6:0] a, logic [7:0] d0, d1, ctl);
    logic [7:0] s;
    wr(H_ADDR, {1'b0, a});
    wr(H_DATA0, d0);
    wr(H_DATA1, d1);
    wr(H_CTRL, ctl);
    for (int n = 0; n < 2000; n++)
    begin
      rd(H_STAT, s);
      if (s[0] === 1'b0)
        break;
    end
    chk("op done", 8'h00, s & 8'h01);
    repeat (4) @(posedge ref_clk_i);
  endtask
  // bitwise crc-8, x^8+x^2+x+1, msb first
  function automatic logic [7:0] crc(logic [7:0] c, logic [7:0] d);
    c ^= d;
    repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction
  task automatic s_cfg();
    logic [7:0] v;
    chk("idle wires", 8'h07, {5'h0, bus.scl, bus.sda, bus.alert_n});
    chk("cfg reset", 8'h01, cfg_o);
    op(ADDR_MAIN, CFG_OFF, 8'h80, 8'h21);
    chk("cfg write", 8'h80, cfg_o);
    op(ADDR_MAIN, CFG_OFF, 8'h00, 8'h11);
    op(ADDR_MAIN, 8'h00, 8'h00, 8'h13);
    rd(H_RDATA, v);
    chk("cfg read", 8'h80, v);
  endtask
  task automatic s_reg();
    logic [7:0] v;
    op(ADDR_MAIN, 8'h05, 8'h5A, 8'h21);
    chk("wr ptr", 8'h05, wa);
    chk("wr data", 8'h5A, wd);
    chk("wr pulses", 8'h01, wr_seen[7:0]);
    op(ADDR_MAIN, 8'h00, 8'h00, 8'h13);
    rd(H_RDATA, v);
    chk("reg read", 8'hA0, v);
    op(ADDR_ALT, 8'h05, 8'h00, 8'h11);
    rd(H_STAT, v);
    chk("other addr", 8'h02, v & 8'h02);
  endtask
  task automatic s_alert();
    logic [7:0] v;
    alarm_cond_i <= 1;
    op(ARA_ADDR, 8'h00, 8'h00, 8'h13);
    chk("alarm wire", 8'h00, {7'h0, bus.alert_n});
    rd(H_RDATA, v);
    chk("ara reply", {ADDR_MAIN, 1'b1}, v);
    rd(H_STAT, v);
    chk("alarm kept", 8'h08, v & 8'h0A);
    alarm_cond_i <= 0;
    op(ARA_ADDR, 8'h00, 8'h00, 8'h13);
    rd(H_STAT, v);
    chk("alarm freed", 8'h00, v & 8'h08);
    op(ARA_ADDR, 8'h00, 8'h00, 8'h13);
    rd(H_STAT, v);
    chk("ara refused", 8'h02, v & 8'h0A);
  endtask
  task automatic s_pec();
    logic [7:0] v;
    op(ADDR_MAIN, CFG_OFF, 8'h00, 8'h11);
    op(ADDR_MAIN, 8'h00, 8'h00, 8'h17);
    rd(H_RPEC, v);
    chk("read pec", crc(crc(8'h00, 8'h99), 8'h80), v);
    rd(H_STAT, v);
    chk("pec flag", 8'h00, v & 8'h04);
    op(ADDR_MAIN, CFG_OFF, 8'h40, 8'h25);
    chk("pec write", 8'h40, cfg_o);
    chk("pec errors", 8'h00, pec_errs[7:0]);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 0;
    repeat (4) @(posedge ref_clk_i);
    s_cfg();
    s_reg();
    s_alert();
    s_pec();
    finish_test();
  end
  // watchdog, well past the expected run length
  initial
  begin
    #300000;
    fail_count++;
    finish_test();
  end
endmodule
